/* File: design/gthc_top.sv */
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
// Function
// - Input is unsigned 16-bit word, full range
// - Above threshold+delta gives 1, at/below threshold-delta 0
// - Inside band output holds previous value
// - Enable by pin 1 or always-enabled constant
// - Disabled: no compare, output frozen
// - Inputs tracked while disabled, used on re-enable
// - Bit 15 is magnitude, never sign
// - Enable from island input, virtual or master bit
// - Operand from analog word or nested block
// - Dedicated channel ignores master data
// - Master bit still written, usable as input
module gthc_top
  import gthc_pkg::*;
#(
  parameter int unsigned WIDTH = GTHC_WIDTH
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic enable_in,
  input wire gthc_pkg::gthc_op_in_t op_in,
  input wire gthc_pkg::gthc_reg_req_t reg_req,
  output logic [15:0] reg_rdata,
  output logic compare_out,
  output logic channel_out
);
  import gthc_pkg::*;

  logic [15:0] ctrl;
  logic [WIDTH-1:0] compare_threshold;
  logic [WIDTH-1:0] delta;
  logic [15:0] master_bits;
  logic [WIDTH-1:0] op_word;
  logic enabled;
  logic next_out;
  logic bad_cfg;
  logic [15:0] next_rdata;
  gthc_en_src_t en_src;

  assign en_src = gthc_en_src_t'(ctrl[GTHC_CTRL_EN_SRC_LSB +: 2]);

  // Enable selection; the master bit is bit 0 of the master word
  always_comb begin
    unique case (en_src)
      GTHC_EN_PIN: enabled = enable_in;
      GTHC_EN_MASTER: enabled = master_bits[0];
      GTHC_EN_ALWAYS: enabled = 1'h1;
      GTHC_EN_NEVER: enabled = 1'h0;
    endcase
  end

  // Operand is taken raw as unsigned, no sign handling
  assign op_word = ctrl[GTHC_CTRL_OP_SRC_BIT] ? op_in.nested_word[WIDTH-1:0]
                                              : op_in.analog_word[WIDTH-1:0];

  gthc_core #(
    .WIDTH(WIDTH)
  ) u_core (
    .value(op_word),
    .compare_threshold(compare_threshold),
    .delta(delta),
    .prev_out(compare_out),
    .next_out(next_out),
    .bad_cfg(bad_cfg)
  );

  // Presets and control written by software
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= GTHC_CTRL_RST;
      compare_threshold <= GTHC_THRESHOLD_RST[WIDTH-1:0];
      delta <= GTHC_DELTA_RST[WIDTH-1:0];
      master_bits <= GTHC_MASTER_BITS_RST;
    end else if (reg_req.wr) begin
      unique case (reg_req.addr)
        GTHC_REG_CTRL: ctrl <= reg_req.wdata;
        GTHC_REG_THRESHOLD: compare_threshold <= reg_req.wdata[WIDTH-1:0];
        GTHC_REG_DELTA: delta <= reg_req.wdata[WIDTH-1:0];
        GTHC_REG_MASTER_BITS: master_bits <= reg_req.wdata;
        default: ;
      endcase
    end
  end

  // Compare result; frozen while disabled, live operands seen on re-enable
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      compare_out <= 1'h0;
    end else if (enabled) begin
      compare_out <= next_out;
    end
  end

  // Physical channel: dedicated follows block, else master bit 1
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      channel_out <= 1'h0;
    end else if (ctrl[GTHC_CTRL_DEDICATE_BIT]) begin
      channel_out <= enabled ? next_out : compare_out;
    end else begin
      channel_out <= master_bits[1];
    end
  end

  // Read mux; unmapped indices read zero
  always_comb begin
    next_rdata = 16'h0000;
    unique case (reg_req.addr)
      GTHC_REG_CTRL: next_rdata = ctrl;
      GTHC_REG_THRESHOLD: next_rdata = 16'(compare_threshold);
      GTHC_REG_DELTA: next_rdata = 16'(delta);
      GTHC_REG_STATUS: begin
        next_rdata[GTHC_STAT_OUT_BIT] = compare_out;
        next_rdata[GTHC_STAT_EN_BIT] = enabled;
        next_rdata[GTHC_STAT_BAD_CFG_BIT] = bad_cfg;
      end
      GTHC_REG_MASTER_BITS: next_rdata = master_bits;
      GTHC_REG_INPUT: next_rdata = 16'(op_word);
      default: next_rdata = 16'h0000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_req.rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule // gthc_top

/* File: design/gthc_pkg.sv */
package gthc_pkg;
  localparam int unsigned GTHC_WIDTH = 16;
  // Register indices on the plain register port
  localparam logic [3:0] GTHC_REG_CTRL = 4'h0;
  localparam logic [3:0] GTHC_REG_THRESHOLD = 4'h1;
  localparam logic [3:0] GTHC_REG_DELTA = 4'h2;
  localparam logic [3:0] GTHC_REG_STATUS = 4'h3;
  localparam logic [3:0] GTHC_REG_MASTER_BITS = 4'h4;
  localparam logic [3:0] GTHC_REG_INPUT = 4'h5;
  // Control field positions
  localparam int unsigned GTHC_CTRL_EN_SRC_LSB = 0;
  localparam int unsigned GTHC_CTRL_OP_SRC_BIT = 2;
  localparam int unsigned GTHC_CTRL_DEDICATE_BIT = 3;
  // Status field positions
  localparam int unsigned GTHC_STAT_OUT_BIT = 0;
  localparam int unsigned GTHC_STAT_EN_BIT = 1;
  localparam int unsigned GTHC_STAT_BAD_CFG_BIT = 2;
  // Reset values
  localparam logic [15:0] GTHC_CTRL_RST = 16'h0000;
  localparam logic [15:0] GTHC_THRESHOLD_RST = 16'h0000;
  localparam logic [15:0] GTHC_DELTA_RST = 16'h0000;
  localparam logic [15:0] GTHC_MASTER_BITS_RST = 16'h0000;

  // Enable source selection
  typedef enum logic [1:0] {
    GTHC_EN_PIN = 2'h0,
    GTHC_EN_MASTER = 2'h1,
    GTHC_EN_ALWAYS = 2'h2,
    GTHC_EN_NEVER = 2'h3
  } gthc_en_src_t;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } gthc_reg_req_t;

  // Operational input sources
  typedef struct packed {
    logic [15:0] analog_word;
    logic [15:0] nested_word;
  } gthc_op_in_t;
endpackage

/* File: design/gthc_core.sv */
`timescale 1ns/1ps
// Hysteresis compare decision, purely combinational
module gthc_core #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic [WIDTH-1:0] value,
  input wire logic [WIDTH-1:0] compare_threshold,
  input wire logic [WIDTH-1:0] delta,
  input wire logic prev_out,
  output logic next_out,
  output logic bad_cfg
);
  logic [WIDTH:0] upper;
  logic [WIDTH:0] lower;
  logic lower_neg;

  // One extra bit so an illegal preset cannot wrap silently
  always_comb begin
    upper = {1'h0, compare_threshold} + {1'h0, delta};
    lower = {1'h0, compare_threshold} - {1'h0, delta};
    lower_neg = lower[WIDTH];
    bad_cfg = upper[WIDTH] | lower_neg;
    if ({1'h0, value} > upper) begin
      next_out = 1'h1;
    end else if (!lower_neg && ({1'h0, value} <= lower)) begin
      next_out = 1'h0;
    end else begin
      next_out = prev_out;
    end
  end
endmodule // gthc_core

/* File: testbench/gthc_sva.sv */
`timescale 1ns/1ps
module gthc_sva
  import gthc_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic enable_in,
  input wire gthc_pkg::gthc_op_in_t op_in,
  input wire gthc_pkg::gthc_reg_req_t reg_req,
  input wire logic [15:0] reg_rdata,
  input wire logic compare_out,
  input wire logic channel_out
);
  logic [15:0] thr, dlt, ctl, mb, op, d;
  logic en, up, dn;
  assign d = reg_req.wdata;
  // Shadow registers, updated on the same edge as the design's
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      {ctl, thr, dlt, mb} <= 64'h0;
    end else if (reg_req.wr) begin
      case (reg_req.addr)
        GTHC_REG_CTRL: ctl <= d;
        GTHC_REG_THRESHOLD: thr <= d;
        GTHC_REG_DELTA: dlt <= d;
        GTHC_REG_MASTER_BITS: mb <= d;
        default: ;
      endcase
    end
  end
  // Widened sum so an overflowing upper limit never trips
  assign op = ctl[2] ? op_in.nested_word : op_in.analog_word;
  assign en = ctl[1:0] == 2'h0 ? enable_in : ctl[1:0] == 2'h1 ? mb[0] : ~ctl[0];
  assign up = en && {1'h0, op} > {1'h0, thr} + dlt;
  assign dn = en && thr >= dlt && op <= thr - dlt;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence s_off;
    !en;
  endsequence
  chk_rise_out: assert property (up |=> compare_out) else $error("no rise");
  chk_fall_out: assert property (dn |=> !compare_out) else $error("no fall");
  chk_band_hold: assert property (en && !up && !dn |=> $stable(compare_out)) else $error("band");
  chk_frozen_off: assert property (s_off |=> $stable(compare_out)) else $error("frozen");
  chk_reset_zero: assert property (disable iff (1'h0) !nrst |-> !compare_out && !channel_out)
    else $error("reset");
  chk_rdata_idle: assert property (!reg_req.rd |=> reg_rdata == 16'h0000) else $error("rdata");
  chk_ded_chan: assert property (ctl[3] |=> channel_out == compare_out) else $error("ded");
  chk_master_chan: assert property (!ctl[3] |=> channel_out == $past(mb[1])) else $error("mb");
endmodule // gthc_sva
bind gthc_top gthc_sva gthc_sva_i(.mclk, .nrst, .enable_in, .op_in, .reg_req, .reg_rdata,
  .compare_out, .channel_out);

/* File: testbench/gthc_island.sv */
`timescale 1ns/1ps
// Island channels: words refresh one edge after the master asks
module gthc_island
  import gthc_pkg::*;
(
  input wire logic mclk,
  input wire logic [15:0] set_ana,
  input wire logic [15:0] set_nst,
  input wire logic set_en,
  output gthc_pkg::gthc_op_in_t op_in = '0,
  output logic enable_in = 1'h0
);
  // Sources give unsigned words only, limits kept in range by the bench
  always @(posedge mclk) begin
    op_in <= {set_ana, set_nst};
    enable_in <= set_en;
  end
endmodule // gthc_island

/* File: testbench/tb.sv */
`timescale 1ns/1ps
module tb;
  import gthc_pkg::*;
  logic mclk = 1'h0;
  logic nrst = 1'h1;
  logic en = 1'h0;
  logic [15:0] ana = 16'h0000;
  gthc_reg_req_t req = '0;
  gthc_op_in_t op_in;
  logic enable_in, compare_out, channel_out;
  logic [15:0] reg_rdata;
  int fails = 0;
  int checked = 0;
  initial begin
    forever #50 mclk = ~mclk;
  end
  gthc_island gthc_island_i(.mclk, .set_ana(ana), .set_nst(16'h0000), .set_en(en), .op_in,
    .enable_in);
  gthc_top gthc_top_i(.mclk, .nrst, .enable_in, .op_in, .reg_req(req), .reg_rdata,
    .compare_out, .channel_out);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // Gap cycle after each strobe so no signal is driven twice in one step
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    req <= '{a, v, 1'h1, 1'h0};
    @(posedge mclk);
    req <= '0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] v);
    req <= '{a, 16'h0000, 1'h0, 1'h1};
    @(posedge mclk);
    req <= '0;
    #1 chk(reg_rdata, v, "reg_rdata");
    @(posedge mclk);
  endtask
  // Model adds one edge, compare another
  task automatic go(input logic [15:0] a, input logic e, input logic x);
    ana <= a;
    en <= e;
    repeat (3) @(posedge mclk);
    #1 chk({15'h0, compare_out}, {15'h0, x}, "compare_out");
    @(posedge mclk);
  endtask
  task automatic end_sim;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    nrst <= 1'h0; // A real falling edge, so outputs are cleared before the first clock edge
    repeat (3) @(posedge mclk);
    nrst <= 1'h1;
    @(posedge mclk);
    rd(GTHC_REG_STATUS, 16'h0000);
    wr(GTHC_REG_THRESHOLD, 16'hBB80);
    wr(GTHC_REG_DELTA, 16'h0020);
    wr(GTHC_REG_CTRL, 16'h0002);
    go(16'hBBA0, 1'h0, 1'h0);
    go(16'hBBA1, 1'h0, 1'h1);
    go(16'hBB61, 1'h0, 1'h1);
    go(16'hBB60, 1'h0, 1'h0);
    go(16'hFFFF, 1'h0, 1'h1);
    wr(GTHC_REG_CTRL, 16'h0003);
    go(16'h0000, 1'h1, 1'h1);
    go(16'h0000, 1'h0, 1'h1);
    wr(GTHC_REG_CTRL, 16'h0000);
    go(16'h0000, 1'h0, 1'h1);
    go(16'h0000, 1'h1, 1'h0);
    wr(GTHC_REG_MASTER_BITS, 16'h0001);
    wr(GTHC_REG_CTRL, 16'h0001);
    go(16'hFFFF, 1'h0, 1'h1);
    wr(GTHC_REG_CTRL, 16'h0006);
    go(16'hFFFF, 1'h0, 1'h0);
    $display("compare test done");
    wr(GTHC_REG_MASTER_BITS, 16'h0002);
    wr(GTHC_REG_CTRL, 16'h000A);
    go(16'h0000, 1'h0, 1'h0);
    #1 chk({15'h0, channel_out}, 16'h0000, "channel_out");
    @(posedge mclk);
    wr(GTHC_REG_CTRL, 16'h0002);
    #1 chk({15'h0, channel_out}, 16'h0001, "channel_out");
    @(posedge mclk);
    rd(GTHC_REG_MASTER_BITS, 16'h0002);
    rd(GTHC_REG_STATUS, 16'h0002);
    rd(4'hF, 16'h0000);
    $display("port test done");
    end_sim;
  end
endmodule // tb
